// ### tsr_params.svh
// Register offsets, field positions, reset values and phase codes of the sample slot block.
`ifndef TSR_PARAMS_SVH
`define TSR_PARAMS_SVH

`define TSR_ADDR_W        12
`define TSR_DATA_W        32
`define TSR_S4_NS_OFS     12'h578
`define TSR_S4_SEC_OFS    12'h57C
`define TSR_S4_PHASE_OFS  12'h580
`define TSR_S5_NS_OFS     12'h584
`define TSR_S5_SEC_OFS    12'h588
`define TSR_S5_PHASE_OFS  12'h58C
`define TSR_POL_BIT       30
`define TSR_RSVD_BIT      31
`define TSR_NS_MSB        29
`define TSR_PHASE_MSB     2
`define TSR_RESET_WORD    32'h00000000
`define TSR_PH_0NS        3'h0
`define TSR_PH_8NS        3'h1
`define TSR_PH_16NS       3'h2
`define TSR_PH_24NS       3'h3
`define TSR_PH_32NS       3'h4

`endif

// ### tsr_pkg.sv
// Types shared by the sample slot block.
`default_nettype none

package tsr_pkg;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed
   {
      logic        pol;
      logic [29:0] ns;
      logic [31:0] sec;
      logic [2:0]  phase;
   } tsr_record_t;

   typedef struct packed
   {
      logic [29:0] ns;
      logic [31:0] sec;
      logic [2:0]  slot;
   } tsr_tod_t;

   typedef enum logic [1:0]
   {
      TSR_F_NS,
      TSR_F_SEC,
      TSR_F_PHASE,
      TSR_F_NONE
   } tsr_field_t;

   typedef enum logic [1:0]
   {
      TSR_IDLE,
      TSR_FETCH,
      TSR_ANSWER
   } tsr_bus_state_t;

endpackage

`default_nettype wire

// ### tsr_slot_store.sv
// Record store with one write strobe per entry and a registered read port.
`default_nettype none

module tsr_slot_store
#(
   parameter int ENTRIES = 4,
   parameter int IDX_W   = 2
)
(
   // Clock and reset.
   input  wire logic                     clk_i,
   input  wire logic                     rst_n_i,
   // Write side.
   input  wire logic [ENTRIES-1:0]       we_i,
   input  wire tsr_pkg::tsr_record_t     wdata_i,
   // Read side.
   input  wire logic [IDX_W-1:0]         raddr_i,
   output var  tsr_pkg::tsr_record_t     rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import tsr_pkg::*;

   tsr_record_t store [ENTRIES];

   if (ENTRIES < 1 || ENTRIES > (1 << IDX_W))
   begin : g_bad
      $error("Entry count does not fit the index width.");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Each entry loads a whole record in one edge, so no record is ever torn.
   for (genvar i = 0; i < ENTRIES; i++)
   begin : g_entry
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
         if (!rst_n_i)
            store[i] <= '0;
         else if (we_i[i])
            store[i] <= wdata_i;
      end

      entry_load_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
         we_i[i] |=> store[i] == $past(wdata_i))
         else $error("Entry did not take the whole record.");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data leave through a register.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_o <= '0;
      else
         rdata_o <= store[raddr_i];
   end

endmodule

`default_nettype wire

// ### tsr_sample_slots.sv
// Fourth and fifth timestamp sample records with a classic Wishbone read port.
//
// The Wishbone interface to the registers was decided locally.
`default_nettype none
`include "tsr_params.svh"

module tsr_sample_slots
#(
   parameter int UNITS = 2
)
(
   // Clock and reset.
   input  wire logic                        clk_i,
   input  wire logic                        rst_n_i,
   // Wishbone slave.
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [`TSR_ADDR_W-1:0]      wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [`TSR_DATA_W-1:0]      wb_dat_i,
   output var  logic [`TSR_DATA_W-1:0]      wb_dat_o,
   output var  logic                        wb_ack_o,
   // Unit index pointer from the global index register.
   input  wire logic                        unit_select_i,
   // Capture strobes and time of day.
   input  wire tsr_pkg::tsr_tod_t           tod_i,
   input  wire logic                        capture_rising_i,
   input  wire logic [UNITS-1:0]            capture4_i,
   input  wire logic [UNITS-1:0]            capture5_i
);
   timeunit 1ns;
   timeprecision 1ps;
   import tsr_pkg::*;

   localparam int ENTRIES = 2 * UNITS;
   localparam int IDX_W   = 2;

   if (UNITS < 1 || UNITS > 2)
   begin : g_bad_units
      $error("A one-bit unit pointer serves one or two units only.");
   end

   tsr_bus_state_t      state;
   tsr_field_t          dec_field;
   tsr_field_t          field_q;
   logic                dec_slot;
   logic                unit_eff;
   logic                req;
   logic [IDX_W-1:0]    rd_entry;
   logic [ENTRIES-1:0]  cap_we;
   tsr_record_t         wr_rec;
   tsr_record_t         rd_rec;
   logic [`TSR_DATA_W-1:0] next_dat;

   ////////////////////////////////////////////////////////////////////////////////
   // Phase code of the 8ns cycle inside the 40ns period.
   function automatic logic [2:0] phase_code(input logic [2:0] slot);
      logic [2:0] code;
      code = `TSR_PH_0NS;
      case (slot)
         3'h0 : code = `TSR_PH_0NS;
         3'h1 : code = `TSR_PH_8NS;
         3'h2 : code = `TSR_PH_16NS;
         3'h3 : code = `TSR_PH_24NS;
         3'h4 : code = `TSR_PH_32NS;
         default : code = `TSR_PH_0NS;
      endcase
      return code;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Capture path: polarity, time and phase form one record.
   always_comb
   begin
      wr_rec.pol   = capture_rising_i;
      wr_rec.ns    = tod_i.ns;
      wr_rec.sec   = tod_i.sec;
      wr_rec.phase = phase_code(tod_i.slot);
   end

   for (genvar u = 0; u < UNITS; u++)
   begin : g_unit
      assign cap_we[2*u]   = capture4_i[u];
      assign cap_we[2*u+1] = capture5_i[u];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode and record selection.
   always_comb
   begin
      dec_field = TSR_F_NONE;
      dec_slot  = 1'b0;
      case (wb_adr_i)
         `TSR_S4_NS_OFS    : dec_field = TSR_F_NS;
         `TSR_S4_SEC_OFS   : dec_field = TSR_F_SEC;
         `TSR_S4_PHASE_OFS : dec_field = TSR_F_PHASE;
         `TSR_S5_NS_OFS    :
         begin
            dec_field = TSR_F_NS;
            dec_slot  = 1'b1;
         end
         `TSR_S5_SEC_OFS   :
         begin
            dec_field = TSR_F_SEC;
            dec_slot  = 1'b1;
         end
         `TSR_S5_PHASE_OFS :
         begin
            dec_field = TSR_F_PHASE;
            dec_slot  = 1'b1;
         end
         default : dec_field = TSR_F_NONE;
      endcase
   end

   assign unit_eff = (UNITS == 2) ? unit_select_i : 1'b0;
   assign rd_entry = {unit_eff, dec_slot};
   assign req      = wb_cyc_i && wb_stb_i;

   tsr_slot_store
   #(
      .ENTRIES (ENTRIES),
      .IDX_W   (IDX_W)
   )
   u_store
   (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .we_i    (cap_we),
      .wdata_i (wr_rec),
      .raddr_i (rd_entry),
      .rdata_o (rd_rec)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Read word formatting; reserved bits read as zero.
   always_comb
   begin
      next_dat = `TSR_RESET_WORD;
      if (!wb_we_i)
      begin
         unique case (field_q)
            TSR_F_NS :
            begin
               next_dat[`TSR_POL_BIT]    = rd_rec.pol;
               next_dat[`TSR_NS_MSB:0]   = rd_rec.ns;
               next_dat[`TSR_RSVD_BIT]   = 1'b0;
            end
            TSR_F_SEC   : next_dat = rd_rec.sec;
            TSR_F_PHASE : next_dat[`TSR_PHASE_MSB:0] = rd_rec.phase;
            TSR_F_NONE  : next_dat = `TSR_RESET_WORD;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus sequencing: take, fetch, answer for one cycle.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state   <= TSR_IDLE;
         field_q <= TSR_F_NONE;
      end
      else
      begin
         unique case (state)
            TSR_IDLE :
            begin
               if (req)
               begin
                  state   <= TSR_FETCH;
                  field_q <= dec_field;
               end
            end
            TSR_FETCH  : state <= TSR_ANSWER;
            TSR_ANSWER : state <= TSR_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= (state == TSR_FETCH);
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         wb_dat_o <= `TSR_RESET_WORD;
      else if (state == TSR_FETCH)
         wb_dat_o <= next_dat;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   ack_timing_a : assert property ((state == TSR_IDLE) && req |=> !wb_ack_o ##1 wb_ack_o ##1 !wb_ack_o)
      else $error("Answer did not come exactly two cycles after the request.");

   unit_pick_a : assert property ((state == TSR_IDLE) && req && (UNITS == 2) |-> rd_entry[1] == unit_select_i)
      else $error("Read did not follow the unit pointer.");

   edge_bit_a : assert property ($rose(wb_ack_o) && (field_q == TSR_F_NS) && !wb_we_i |->
      wb_dat_o[`TSR_POL_BIT] == $past(rd_rec.pol))
      else $error("Polarity bit differs from the stored edge.");

   ns_field_a : assert property ($rose(wb_ack_o) && (field_q == TSR_F_NS) && !wb_we_i |->
      !wb_dat_o[`TSR_RSVD_BIT] && wb_dat_o[`TSR_NS_MSB:0] == $past(rd_rec.ns))
      else $error("Nanoseconds word is wrong.");

   sec_field_a : assert property ($rose(wb_ack_o) && (field_q == TSR_F_SEC) && !wb_we_i |->
      wb_dat_o == $past(rd_rec.sec))
      else $error("Seconds word is wrong.");

   phase_range_a : assert property ($rose(wb_ack_o) && (field_q == TSR_F_PHASE) |->
      wb_dat_o[`TSR_DATA_W-1:`TSR_PHASE_MSB+1] == '0 && wb_dat_o[`TSR_PHASE_MSB:0] <= `TSR_PH_32NS)
      else $error("Phase word holds a reserved code.");

   third_slot_a : assert property ((|cap_we) && (tod_i.slot == 3'h2) |-> wr_rec.phase == `TSR_PH_16NS)
      else $error("Third 8ns slot not coded as 010.");

   record_load_a : assert property ((|cap_we) |-> wr_rec.sec == tod_i.sec && wr_rec.ns == tod_i.ns
      && wr_rec.pol == capture_rising_i)
      else $error("Capture record mixes sources.");

endmodule

`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the fourth and fifth sample record block.
`default_nettype none
`include "tsr_params.svh"
module tb_top
   import tsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_i   = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        cyc     = 1'b0;
   logic        stb     = 1'b0;
   logic        we      = 1'b0;
   logic [11:0] adr     = 12'h000;
   logic [31:0] wdat    = 32'h00000000;
   logic [31:0] dat_o;
   logic        ack;
   logic        usel    = 1'b0;
   tsr_tod_t    tod     = '0;
   logic        rise    = 1'b0;
   logic [1:0]  c4      = 2'h0;
   logic [1:0]  c5      = 2'h0;
   logic [31:0] d;
   logic [31:0] ens;
   logic [2:0]  sl;
   logic [2:0]  ph [0:7] = '{`TSR_PH_0NS, `TSR_PH_8NS, `TSR_PH_16NS, `TSR_PH_24NS, `TSR_PH_32NS, 3'h0, 3'h0, 3'h0};
   int          failures    = 0;
   int          comparisons = 0;

   tsr_sample_slots #(.UNITS(2)) tsr_sample_slots_inst
   (
      .clk_i            (clk_i),
      .rst_n_i          (rst_n_i),
      .wb_cyc_i         (cyc),
      .wb_stb_i         (stb),
      .wb_we_i          (we),
      .wb_adr_i         (adr),
      .wb_sel_i         (4'hF),
      .wb_dat_i         (wdat),
      .wb_dat_o         (dat_o),
      .wb_ack_o         (ack),
      .unit_select_i    (usel),
      .tod_i            (tod),
      .capture_rising_i (rise),
      .capture4_i       (c4),
      .capture5_i       (c5)
   );

   always #5 clk_i = ~clk_i;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (failures == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One classic Wishbone cycle, held until ack is sampled high.
   task automatic bus(input logic w, input logic u, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= wd;
      usel <= u;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         failures++;
         end_sim();
      end
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rc(input logic u, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, u, a, 32'h00000000, r);
      chk($sformatf("read %h unit %0d", a, u), e, r);
   endtask

   task automatic cap(input logic [1:0] m4, input logic [1:0] m5, input logic pol,
                      input logic [2:0] s, input logic [29:0] ns, input logic [31:0] sec);
      @(posedge clk_i);
      tod <= '{ns: ns, sec: sec, slot: s};
      rise <= pol;
      c4 <= m4;
      c5 <= m5;
      @(posedge clk_i);
      c4 <= 2'h0;
      c5 <= 2'h0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int u = 0; u < 2; u++)
         for (int i = 0; i < 6; i++)
            rc(u[0], 12'h578 + 12'(4 * i), `TSR_RESET_WORD);
      for (int s = 0; s < 6; s++)
      begin
         sl = (s == 5) ? 3'h7 : s[2:0];
         cap(2'h2, 2'h1, s[0], sl, 30'h3FFFFFF0 + 30'(s), 32'hF0000000 + 32'(s));
         ens = {1'b0, s[0], 30'h3FFFFFF0 + 30'(s)};
         rc(1'b1, `TSR_S4_NS_OFS, ens);
         rc(1'b1, `TSR_S4_SEC_OFS, 32'hF0000000 + 32'(s));
         rc(1'b1, `TSR_S4_PHASE_OFS, {29'h0, ph[sl]});
         rc(1'b0, `TSR_S5_NS_OFS, ens);
         rc(1'b0, `TSR_S5_SEC_OFS, 32'hF0000000 + 32'(s));
         rc(1'b0, `TSR_S5_PHASE_OFS, {29'h0, ph[sl]});
         rc(1'b0, `TSR_S4_NS_OFS, 32'h00000000);
         rc(1'b1, `TSR_S5_SEC_OFS, 32'h00000000);
      end
      bus(1'b1, 1'b1, `TSR_S4_NS_OFS, 32'hFFFFFFFF, d);
      chk("write answer", 32'h00000000, d);
      rc(1'b1, `TSR_S4_NS_OFS, ens);
      rc(1'b0, 12'h590, 32'h00000000);
      rc(1'b0, 12'h574, 32'h00000000);
      cap(2'h1, 2'h1, 1'b1, 3'h2, 30'h15555555, 32'h12345678);
      rc(1'b0, `TSR_S4_SEC_OFS, 32'h12345678);
      rc(1'b0, `TSR_S5_NS_OFS, 32'h55555555);
      rc(1'b0, `TSR_S4_PHASE_OFS, 32'h00000002);
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      rc(1'b1, `TSR_S4_SEC_OFS, `TSR_RESET_WORD);
      end_sim();
   end
endmodule
`default_nettype wire
